// File: design/ahpc_top.v
// host port control: strobe decode, second control register, fifo and data-ready
// Operation
// - soft reset clears registers, fifo, offset
// - wait five conversion clocks before storing
// - read bit 1 shows fifo overrun
// - reading the register clears overrun flag
// - writing bit 1 flushes the fifo
// - fill reaching trigger count asserts data-ready
// - one/two channel trigger level decode
// - three/four channel decode, code 11 reserved with four channels
// - each channel counts once, fixed order
// - bit 4 selects level or pulse
// - bit 5 selects data-ready polarity
// - bit 6 set makes write pin direction
// - bit 6 clear uses separate strobes
// - bit 7 selects output number format
// - bit 8 calibrates and subtracts offset
// - readback returns register zero, then one
// - fetch needs both selects, read, no write; with bit 6 set, both selects and write pin high
// - store needs both selects, write, no read; with bit 6 set, both selects and write pin low
// - pulses end with first inactive signal
// - level mode clears on first read
// - pulse lasts half a sample clock
// - no new pulse before trigger reads done
`timescale 1ns/1ps
`include "ahpc_map.vh"
module ahpc_top #(
    parameter SW = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire REF_CLK_I, // 50 MHz clock
    input wire NRST_I, // async reset, active low
    input wire SELECT_LOW_N_I, // chip select, active low
    input wire SELECT_HIGH_I, // chip select, active high
    input wire READ_N_I, // read strobe, active low
    input wire WRITE_N_I, // write strobe or read/write direction
    input wire [9:0] DATA_I, // bus data in
    output reg [11:0] DATA_O, // bus data out
    output reg DATA_OE_O, // bus data drive enable
    input wire SAMPLE_CLOCK_IN_I, // conversion clock from the core side
    input wire [SW-1:0] SAMPLE_I, // converted sample
    input wire SAMPLE_VALID_I, // sample strobe, same clock
    input wire ZERO_INPUT_I, // sample taken with inputs held at zero
    input wire [2:0] CHAN_COUNT_I, // active channels 1..4
    output reg CAL_REQ_O, // asks the core for a zero-input conversion
    output reg [9:0] CTRL0_O, // first control register contents
    output reg OVERRUN_O, // fifo overrun flag state
    output reg SAMPLE_READY_O, // data-ready output
    output reg SAMPLE_IN_READY_O // fifo can take a sample
);
    reg [2:0] sel_lo_sync;
    reg [2:0] sel_hi_sync;
    reg [2:0] rd_sync;
    reg [2:0] wr_sync;
    reg [2:0] sclk_sync;
    reg sel_lo_reg;
    reg sel_hi_reg;
    reg rd_reg;
    reg wr_reg;
    reg sclk_reg;
    reg fetch_d_reg;
    reg store_d_reg;
    reg [9:0] ctrl0_reg;
    reg [9:0] ctrl1_reg;
    reg overrun_reg;
    reg [SW-1:0] offset_reg;
    reg cal_pend_reg;
    reg [2:0] start_cnt_reg;
    reg [1:0] config_readback_en_reg;
    reg [4:0] drain_reg;
    reg armed_reg;
    reg dav_act_reg;
    reg pulse_pend_reg;
    wire [SW-1:0] fifo_out;
    wire fifo_valid;
    wire fifo_in_ready;
    wire [AW:0] fifo_count;
    wire cs_ok;
    wire rw_mode;
    wire fetch;
    wire store;
    wire fetch_rise;
    wire store_rise;
    wire flush;
    wire sclk_rise;
    wire sclk_fall;
    wire [4:0] trig_lvl;
    wire push_ok;
    wire [SW-1:0] corrected;
    wire pop;

    // readback sequence: idle, next fetch gives register zero, then register one
    localparam RB_IDLE = 2'b00;
    localparam RB_CR0 = 2'b11;
    localparam RB_CR1 = 2'b01;

    // trigger count decode by active channel count
    function [4:0] trig_decode;
        input [2:0] chans;
        input [1:0] code;
        begin
            case (chans)
                3'd1: begin
                    case (code)
                        2'd0: trig_decode = 5'd1;
                        2'd1: trig_decode = 5'd4;
                        2'd2: trig_decode = 5'd8;
                        default: trig_decode = 5'd14;
                    endcase
                end
                3'd2: begin
                    case (code)
                        2'd0: trig_decode = 5'd2;
                        2'd1: trig_decode = 5'd4;
                        2'd2: trig_decode = 5'd8;
                        default: trig_decode = 5'd12;
                    endcase
                end
                3'd3: begin
                    case (code)
                        2'd0: trig_decode = 5'd3;
                        2'd1: trig_decode = 5'd6;
                        2'd2: trig_decode = 5'd9;
                        default: trig_decode = 5'd12;
                    endcase
                end
                3'd4: begin
                    case (code)
                        2'd0: trig_decode = 5'd4;
                        2'd1: trig_decode = 5'd8;
                        2'd2: trig_decode = 5'd12;
                        // reserved code never reaches the fifo depth
                        default: trig_decode = 5'd31;
                    endcase
                end
                default: trig_decode = 5'd1;
            endcase
        end
    endfunction

    // word placed on the bus by a fetch: readback registers or the formatted sample
    function [11:0] fetch_word;
        input [1:0] rb;
        input [9:0] c0;
        input [9:0] c1;
        input ovr;
        input [11:0] smp;
        begin
            case (rb)
                RB_CR0: fetch_word = {2'b00, c0};
                RB_CR1: fetch_word = {2'b00, c1[9:2], ovr, 1'b0};
                default: begin
                    if (c1[`AHPC_BIT_FORMAT]) begin
                        fetch_word = smp ^ 12'h0800;
                    end else begin
                        fetch_word = smp;
                    end
                end
            endcase
        end
    endfunction

    // pin inputs pass three flops; a change counts when stages two and three agree
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            sel_lo_sync <= 3'b111;
            sel_hi_sync <= 3'b000;
            rd_sync <= 3'b111;
            wr_sync <= 3'b111;
            sclk_sync <= 3'b000;
            sel_lo_reg <= 1'b1;
            sel_hi_reg <= 1'b0;
            rd_reg <= 1'b1;
            wr_reg <= 1'b1;
            sclk_reg <= 1'b0;
        end else begin
            sel_lo_sync <= {sel_lo_sync[1:0], SELECT_LOW_N_I};
            sel_hi_sync <= {sel_hi_sync[1:0], SELECT_HIGH_I};
            rd_sync <= {rd_sync[1:0], READ_N_I};
            wr_sync <= {wr_sync[1:0], WRITE_N_I};
            sclk_sync <= {sclk_sync[1:0], SAMPLE_CLOCK_IN_I};
            if (sel_lo_sync[1] == sel_lo_sync[2]) sel_lo_reg <= sel_lo_sync[2];
            if (sel_hi_sync[1] == sel_hi_sync[2]) sel_hi_reg <= sel_hi_sync[2];
            if (rd_sync[1] == rd_sync[2]) rd_reg <= rd_sync[2];
            if (wr_sync[1] == wr_sync[2]) wr_reg <= wr_sync[2];
            if (sclk_sync[1] == sclk_sync[2]) sclk_reg <= sclk_sync[2];
        end
    end

    assign cs_ok = !sel_lo_reg && sel_hi_reg;
    assign rw_mode = ctrl1_reg[`AHPC_BIT_RWMODE];
    // combined direction mode ignores the read pin
    assign fetch = cs_ok && (rw_mode ? wr_reg : (!rd_reg && wr_reg));
    assign store = cs_ok && (rw_mode ? !wr_reg : (!wr_reg && rd_reg));
    assign fetch_rise = fetch && !fetch_d_reg;
    assign store_rise = store && !store_d_reg;
    // edges of the filtered sample clock, one cycle ahead of sclk_reg
    assign sclk_rise = sclk_sync[2] && sclk_sync[1] && !sclk_reg;
    assign sclk_fall = !sclk_sync[2] && !sclk_sync[1] && sclk_reg;
    assign flush = store_rise && (DATA_I[`AHPC_BIT_RESET] || DATA_I[`AHPC_BIT_FIFO_OVERRUN_FLAG]);
    assign trig_lvl = trig_decode(CHAN_COUNT_I, ctrl1_reg[`AHPC_BIT_TRIG_MSB:`AHPC_BIT_TRIG_LSB]);
    assign corrected = SAMPLE_I - offset_reg;
    // samples arrive in channel order; one entry per channel, zero-input samples are not stored
    assign push_ok = SAMPLE_VALID_I && !ZERO_INPUT_I && start_cnt_reg == 3'd0;
    assign pop = fetch_rise && !config_readback_en_reg[1] && !config_readback_en_reg[0] && fifo_valid;

    ahpc_fifo #(
        .WIDTH(SW),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_fifo (
        .clk_i(REF_CLK_I),
        .nrst_i(NRST_I),
        .flush_i(flush),
        .in_data_i(corrected),
        .in_valid_i(push_ok),
        .in_ready_o(fifo_in_ready),
        .out_data_o(fifo_out),
        .out_valid_o(fifo_valid),
        .out_ready_i(pop),
        .count_o(fifo_count)
    );

    // control registers, overrun, offset, readback sequencing
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            fetch_d_reg <= 1'b0;
            store_d_reg <= 1'b0;
            ctrl0_reg <= `AHPC_CR0_RESET;
            ctrl1_reg <= `AHPC_CR1_RESET;
            overrun_reg <= 1'b0;
            offset_reg <= {SW{1'b0}};
            cal_pend_reg <= 1'b0;
            start_cnt_reg <= 3'd0;
            config_readback_en_reg <= 2'b00;
        end else begin
            fetch_d_reg <= fetch;
            store_d_reg <= store;
            if (store_rise && DATA_I[`AHPC_BIT_RESET]) begin
                ctrl0_reg <= `AHPC_CR0_RESET;
                ctrl1_reg <= `AHPC_CR1_RESET;
                offset_reg <= {SW{1'b0}};
                overrun_reg <= 1'b0;
                cal_pend_reg <= 1'b0;
                config_readback_en_reg <= 2'b00;
                start_cnt_reg <= `AHPC_START_WAIT;
            end else begin
                if (start_cnt_reg != 3'd0 && sclk_rise) begin
                    start_cnt_reg <= start_cnt_reg - 3'd1;
                end
                if (store_rise) begin
                    // reset and flush action bits 0 and 1 are not stored
                    ctrl1_reg <= DATA_I & 10'h3FC;
                    if (DATA_I[`AHPC_BIT_OFFSET]) cal_pend_reg <= 1'b1;
                    if (DATA_I[`AHPC_BIT_CONFIG_READBACK_EN]) config_readback_en_reg <= 2'b11;
                end
                if (cal_pend_reg && SAMPLE_VALID_I && ZERO_INPUT_I) begin
                    offset_reg <= SAMPLE_I;
                    cal_pend_reg <= 1'b0;
                    ctrl1_reg[`AHPC_BIT_OFFSET] <= 1'b0;
                end
                if (fetch_rise && config_readback_en_reg != 2'b00) begin
                    config_readback_en_reg <= {1'b0, config_readback_en_reg[1]};
                end
                // set wins over the read clear
                if (SAMPLE_VALID_I && !ZERO_INPUT_I && !fifo_in_ready) begin
                    overrun_reg <= 1'b1;
                end else if (fetch_rise && config_readback_en_reg == 2'b01) begin
                    overrun_reg <= 1'b0;
                end
            end
        end
    end

    // data-ready generation
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            drain_reg <= 5'd0;
            armed_reg <= 1'b1;
            dav_act_reg <= 1'b0;
            pulse_pend_reg <= 1'b0;
        end else if (flush) begin
            drain_reg <= 5'd0;
            armed_reg <= 1'b1;
            dav_act_reg <= 1'b0;
            pulse_pend_reg <= 1'b0;
        end else begin
            if (armed_reg && {1'b0, fifo_count} >= trig_lvl) begin
                armed_reg <= 1'b0;
                drain_reg <= trig_lvl;
                // level mode raises at once; a pulse waits for the next sample clock rise
                dav_act_reg <= !ctrl1_reg[`AHPC_BIT_SHAPE];
                pulse_pend_reg <= ctrl1_reg[`AHPC_BIT_SHAPE];
            end else begin
                if (pop) begin
                    dav_act_reg <= 1'b0;
                    if (drain_reg <= 5'd1) armed_reg <= 1'b1;
                    if (drain_reg != 5'd0) drain_reg <= drain_reg - 5'd1;
                end
                // pulse spans one high phase of the filtered sample clock unless a fifo read ends it early
                if (pulse_pend_reg && sclk_rise) begin
                    dav_act_reg <= 1'b1;
                    pulse_pend_reg <= 1'b0;
                end
                if (ctrl1_reg[`AHPC_BIT_SHAPE] && sclk_fall) begin
                    dav_act_reg <= 1'b0;
                end
            end
        end
    end

    // registered outputs
    always @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            DATA_O <= 12'h0000;
            DATA_OE_O <= 1'b0;
            CAL_REQ_O <= 1'b0;
            CTRL0_O <= `AHPC_CR0_RESET;
            OVERRUN_O <= 1'b0;
            SAMPLE_READY_O <= 1'b0;
            SAMPLE_IN_READY_O <= 1'b0;
        end else begin
            DATA_OE_O <= fetch;
            if (fetch_rise) begin
                DATA_O <= fetch_word(config_readback_en_reg, ctrl0_reg, ctrl1_reg, overrun_reg, fifo_out);
            end
            CAL_REQ_O <= cal_pend_reg;
            CTRL0_O <= ctrl0_reg;
            OVERRUN_O <= overrun_reg;
            SAMPLE_READY_O <= dav_act_reg ~^ ctrl1_reg[`AHPC_BIT_POL];
            SAMPLE_IN_READY_O <= fifo_in_ready && start_cnt_reg == 3'd0;
        end
    end
endmodule

// File: design/ahpc_map.vh
// register bit positions, reset values and timing counts for the host port control block
`ifndef AHPC_MAP_VH
`define AHPC_MAP_VH
`define AHPC_BIT_RESET 0
`define AHPC_BIT_FIFO_OVERRUN_FLAG 1
`define AHPC_BIT_TRIG_LSB 2
`define AHPC_BIT_TRIG_MSB 3
`define AHPC_BIT_SHAPE 4
`define AHPC_BIT_POL 5
`define AHPC_BIT_RWMODE 6
`define AHPC_BIT_FORMAT 7
`define AHPC_BIT_OFFSET 8
`define AHPC_BIT_CONFIG_READBACK_EN 9
`define AHPC_CR1_RESET 10'h030
`define AHPC_CR0_RESET 10'h000
`define AHPC_START_WAIT 3'd5
`endif

// File: design/ahpc_fifo.v
// synchronous sample fifo with valid/ready on both sides and a flush input
`timescale 1ns/1ps
module ahpc_fifo #(
    parameter WIDTH = 12,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    input wire clk_i, // clock
    input wire nrst_i, // async reset, active low
    input wire flush_i, // empties the fifo
    input wire [WIDTH-1:0] in_data_i, // write data
    input wire in_valid_i, // write request
    output wire in_ready_o, // not full
    output wire [WIDTH-1:0] out_data_o, // head word
    output wire out_valid_o, // not empty
    input wire out_ready_i, // pop
    output wire [AW:0] count_o // fill count
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_reg;
    reg [AW-1:0] rd_ptr_reg;
    reg [AW:0] count_reg;
    wire push;
    wire pop;

    assign in_ready_o = (count_reg != DEPTH[AW:0]);
    assign out_valid_o = (count_reg != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr_reg];
    assign count_o = count_reg;
    assign push = in_valid_i & in_ready_o;
    assign pop = out_ready_i & out_valid_o;

    always @(posedge clk_i) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data_i;
        end
    end

    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                    rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end
endmodule

// File: sim/ahpc_chk_assertions.sv
// concurrent checks on the host port control block ports
`timescale 1ns/1ps
module ahpc_chk (
    input wire logic REF_CLK_I, // clock
    input wire logic NRST_I, // reset, active low
    input wire logic SELECT_LOW_N_I, // select, active low
    input wire logic SELECT_HIGH_I, // select, active high
    input wire logic WRITE_N_I, // write strobe or direction
    input wire logic [11:0] DATA_O, // bus data out
    input wire logic DATA_OE_O, // bus drive enable
    input wire logic SAMPLE_VALID_I, // sample strobe
    input wire logic ZERO_INPUT_I, // zero-input sample
    input wire logic CAL_REQ_O, // calibration pending
    input wire logic [9:0] CTRL0_O, // first control register
    input wire logic OVERRUN_O, // overrun flag
    input wire logic SAMPLE_IN_READY_O // fifo has room
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    oe_needs_sel_a: assert property ($rose(DATA_OE_O) |-> !SELECT_LOW_N_I && SELECT_HIGH_I)
        else $error("drive enable without both selects");
    data_in_fetch_a: assert property ($changed(DATA_O) |-> !SELECT_LOW_N_I && SELECT_HIGH_I)
        else $error("output word changed outside an access");
    oe_ends_a: assert property (SELECT_LOW_N_I [*8] |-> !DATA_OE_O)
        else $error("drive enable outlived the select");
    no_oe_write_a: assert property (!WRITE_N_I [*8] |-> !DATA_OE_O)
        else $error("drive enable during a store");
    ctrl0_kept_a: assert property (CTRL0_O == 10'h000)
        else $error("first control register left reset");
    ovr_sets_a: assert property (!SAMPLE_IN_READY_O && SAMPLE_VALID_I && !ZERO_INPUT_I
        |-> ##[1:2] OVERRUN_O)
        else $error("overrun flag not set");
    ovr_holds_a: assert property ((OVERRUN_O && SELECT_LOW_N_I) [*6] |=> OVERRUN_O)
        else $error("overrun flag lost without a read");
    cal_clears_a: assert property (CAL_REQ_O && SAMPLE_VALID_I && ZERO_INPUT_I
        |-> ##[1:8] !CAL_REQ_O)
        else $error("calibration request stuck");
endmodule
bind ahpc_top ahpc_chk i_chk (.REF_CLK_I(REF_CLK_I), .NRST_I(NRST_I),
    .SELECT_LOW_N_I(SELECT_LOW_N_I), .SELECT_HIGH_I(SELECT_HIGH_I), .WRITE_N_I(WRITE_N_I),
    .DATA_O(DATA_O), .DATA_OE_O(DATA_OE_O), .SAMPLE_VALID_I(SAMPLE_VALID_I),
    .ZERO_INPUT_I(ZERO_INPUT_I), .CAL_REQ_O(CAL_REQ_O), .CTRL0_O(CTRL0_O),
    .OVERRUN_O(OVERRUN_O), .SAMPLE_IN_READY_O(SAMPLE_IN_READY_O));

// File: sim/ahpc_core.sv
// conversion core model: sample clock, sample bursts, zero-input answer
`timescale 1ns/1ps
module ahpc_core (
    input wire logic clk_i, // clock
    input wire logic nrst_i, // reset, active low
    input wire logic ld_i, // load a burst
    input wire logic [4:0] n_i, // burst length
    input wire logic cal_i, // calibration pending
    output logic sclk_o, // conversion clock
    output logic [11:0] smp_o, // sample
    output logic vld_o, // sample strobe
    output logic zero_o, // zero-input sample
    output logic busy_o // burst running
);
    logic [1:0] div_reg;
    logic [4:0] left_reg;
    logic [11:0] val_reg;
    assign busy_o = left_reg != 5'h0;
    always @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            div_reg <= 2'h0;
            sclk_o <= 1'b0;
            left_reg <= 5'h0;
            val_reg <= 12'h100;
            smp_o <= 12'h000;
            vld_o <= 1'b0;
            zero_o <= 1'b0;
        end else begin
            div_reg <= div_reg + 2'h1;
            vld_o <= 1'b0;
            zero_o <= 1'b0;
            // no stale value outside a strobe
            smp_o <= ~smp_o;
            if (div_reg == 2'h3) begin
                sclk_o <= ~sclk_o;
            end
            if (ld_i) begin
                left_reg <= n_i;
            end else if (div_reg == 2'h3 && !sclk_o && cal_i) begin
                vld_o <= 1'b1;
                zero_o <= 1'b1;
                smp_o <= 12'h010;
            end else if (div_reg == 2'h3 && !sclk_o && busy_o) begin
                vld_o <= 1'b1;
                smp_o <= val_reg;
                val_reg <= val_reg + 12'h001;
                left_reg <= left_reg - 5'h1;
            end
        end
    end
endmodule

// File: sim/tb_top.sv
// testbench for the host port control block
`timescale 1ns/1ps
module tb_top;
    logic clk, nrst, sl_n, sh, rd_n, wr_n, sv, zr, cal, oe, ovr, rdy, irdy, scl, ld, busy;
    logic oe_seen;
    logic [9:0] din, c0;
    logic [11:0] dout, smp, nv, q;
    logic [2:0] chn;
    logic [4:0] nb;
    int failures, checks, cyc, i, w;
    // chans, trigger code, polarity, expected level
    logic [9:0] rows [10] = '{10'h091, 10'h0A4, 10'h0D8, 10'h102, 10'h134,
        10'h148, 10'h193, 10'h1A6, 10'h214, 10'h228};
    ahpc_top i_dut (.REF_CLK_I(clk), .NRST_I(nrst), .SELECT_LOW_N_I(sl_n),
        .SELECT_HIGH_I(sh), .READ_N_I(rd_n), .WRITE_N_I(wr_n), .DATA_I(din),
        .DATA_O(dout), .DATA_OE_O(oe), .SAMPLE_CLOCK_IN_I(scl), .SAMPLE_I(smp),
        .SAMPLE_VALID_I(sv), .ZERO_INPUT_I(zr), .CHAN_COUNT_I(chn), .CAL_REQ_O(cal),
        .CTRL0_O(c0), .OVERRUN_O(ovr), .SAMPLE_READY_O(rdy), .SAMPLE_IN_READY_O(irdy));
    ahpc_core i_core (.clk_i(clk), .nrst_i(nrst), .ld_i(ld), .n_i(nb), .cal_i(cal),
        .sclk_o(scl), .smp_o(smp), .vld_o(sv), .zero_o(zr), .busy_o(busy));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
        checks++;
        if (g !== e) begin
            failures++;
            $display("unexpected %s exp %h got %h", n, e, g);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // strobes set up first, selects become valid last
    task automatic bus(input logic r, input logic wn, input logic [9:0] d);
        @(posedge clk);
        rd_n <= r;
        wr_n <= wn;
        din <= d;
        @(posedge clk);
        sl_n <= 1'b0;
        sh <= 1'b1;
        oe_seen = 1'b0;
        repeat (8) begin
            @(posedge clk);
            oe_seen |= oe;
        end
        q = dout;
        sl_n <= 1'b1;
        sh <= 1'b0;
        repeat (2) @(posedge clk);
        rd_n <= 1'b1;
        wr_n <= 1'b1;
        repeat (8) @(posedge clk);
    endtask
    task automatic emit(input int n);
        int k;
        @(posedge clk);
        nb <= n[4:0];
        ld <= 1'b1;
        @(posedge clk);
        ld <= 1'b0;
        w = 0;
        k = 0;
        repeat (2) @(posedge clk);
        while (busy && k < 200) begin
            @(posedge clk);
            k++;
        end
        repeat (24) begin
            @(posedge clk);
            w += rdy;
        end
        nv = nv + n[11:0];
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            failures++;
            report_and_stop();
        end
    end
    initial begin
        nrst = 1'b0;
        sl_n = 1'b1;
        sh = 1'b0;
        rd_n = 1'b1;
        wr_n = 1'b1;
        din = 10'h000;
        chn = 3'h1;
        ld = 1'b0;
        nb = 5'h00;
        nv = 12'h100;
        repeat (12) @(posedge clk);
        nrst <= 1'b1;
        repeat (60) @(posedge clk);
        chk("oe", 12'h000, {11'h000, oe});
        bus(1, 0, 10'h230);
        bus(0, 1, 10'h000);
        chk("rb0", 12'h000, q);
        bus(0, 1, 10'h000);
        chk("rb1", 12'h230, {2'h0, q[9:0]});
        // code 11 is never used with four channels
        for (i = 0; i < 10; i++) begin
            chn <= rows[i][9:7];
            bus(1, 0, {4'h0, rows[i][4], 1'b0, rows[i][6:5], 2'h2});
            emit(rows[i][3:0] - 1);
            chk("idle", {11'h000, ~rows[i][4]}, {11'h000, rdy});
            emit(1);
            chk("trig", {11'h000, rows[i][4]}, {11'h000, rdy});
            bus(0, 1, 10'h000);
            chk("word", nv - rows[i][3:0], q);
            chk("clear", {11'h000, ~rows[i][4]}, {11'h000, rdy});
        end
        chn <= 3'h1;
        bus(1, 0, 10'h0A2);
        emit(2);
        bus(0, 1, 10'h000);
        chk("fmt", (nv - 12'h002) ^ 12'h800, q);
        bus(0, 1, 10'h000);
        chk("order", (nv - 12'h001) ^ 12'h800, q);
        bus(1, 0, 10'h022);
        emit(10);
        chk("ovr", 12'h001, {11'h000, ovr});
        chk("full", 12'h000, {11'h000, irdy});
        bus(1, 0, 10'h220);
        bus(0, 1, 10'h000);
        bus(0, 1, 10'h000);
        chk("rb_ovr", 12'h222, {2'h0, q[9:0]});
        chk("ovr_clr", 12'h000, {11'h000, ovr});
        bus(1, 0, 10'h022);
        chk("flush", 12'h001, {11'h000, irdy});
        bus(1, 0, 10'h062);
        emit(1);
        bus(1, 1, 10'h000);
        chk("rw_rd", nv - 12'h001, q);
        bus(0, 0, 10'h030);
        emit(1);
        bus(1, 1, 10'h000);
        chk("no_fetch", 12'h000, {11'h000, oe_seen});
        bus(0, 1, 10'h000);
        chk("sep_rd", nv - 12'h001, q);
        bus(1, 0, 10'h032);
        emit(1);
        chk("pulse", 12'h001, {11'h000, w > 0 && w < 6});
        emit(1);
        chk("again", 12'h000, {11'h000, w > 0});
        bus(1, 0, 10'h132);
        repeat (40) @(posedge clk);
        emit(1);
        bus(0, 1, 10'h000);
        chk("cal", nv - 12'h011, q);
        bus(1, 0, 10'h001);
        repeat (60) @(posedge clk);
        emit(1);
        bus(0, 1, 10'h000);
        chk("srst", nv - 12'h001, q);
        report_and_stop();
    end
endmodule
